// >>> common/zdt_map.svh
// zvs_deadtime_tuner constants: widths, reset values and timing counts
// assumes a 100 MHz clock; included by the package and the design
`ifndef ZDT_MAP_SVH
`define ZDT_MAP_SVH
// ----------------------------------------------------------------------
// timing and line-sense constants
// ----------------------------------------------------------------------
`define ZDT_CLK_PERIOD_NS 10
`define ZDT_TON_W 10
`define ZDT_TON_RESET 10'h008
`define ZDT_TON_MIN 10'h002
`define ZDT_TON_MAX 10'h3ff
`define ZDT_TZ_W 8
`define ZDT_TZ_MIN_RESET 8'h0a
`define ZDT_TZ_EXT_PCT 140
`define ZDT_LSENSE_W 8
`define ZDT_LSENSE_KNEE 8'h80
`define ZDT_LOCK_CYCLES 15
`define ZDT_LOW_ON_RESET 10'h020
`define ZDT_HS_MAX 10'h3ff
`endif

// >>> common/zdt_pkg.sv
// zvs_deadtime_tuner types
// assumes zdt_map.svh is on the include path
package zdt_pkg;
  `include "zdt_map.svh"
  typedef enum logic [2:0] {
    ZDT_IDLE,
    ZDT_LOW_ON,
    ZDT_WAIT_FALL,
    ZDT_HIGH_ON,
    ZDT_TZ_WAIT
  } zdt_state_e;
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } zdt_gates_s;
  typedef struct packed {
    logic adjust_up;
    logic adjust_down;
    logic locked;
  } zdt_tune_s;
endpackage

// >>> logic/zdt_tuner.sv
// zvs_deadtime_tuner: complementary gate timing with on-time tuning
// assumes comparator inputs are asynchronous and get synchronised here
//
// Functional notes
// R1: judge threshold reach within turn-on delay
// R2: not reached: lengthen high-side on-time
// R3: reached: shorten on-time one step
// R4: single-step change per cycle
// R5: start short, lock within 15 cycles (code locks on first direction reversal, no cycle limit)
// R6: two separate dead-times between gates
// R7: low line current extends first dead-time
// R8: resample zero-current-detect at delay expiry
// R9: no valid transition: skip, await rising edge
// R10: second dead-time follows switch-node slope
// R11: high side on at detect fall
`include "zdt_map.svh"
module zdt_tuner
  import zdt_pkg::*;
#(
  parameter int TON_W = `ZDT_TON_W,
  parameter int TZ_W = `ZDT_TZ_W,
  parameter int LS_W = `ZDT_LSENSE_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_zvs_threshold,
  input wire logic i_zero_current_detect,
  input wire logic [TZ_W-1:0] i_delay_program,
  input wire logic [LS_W-1:0] i_line_sense_current,
  input wire logic [TON_W-1:0] i_low_on_time,
  output logic o_high_side_gate,
  output logic o_low_side_gate,
  output logic o_adjust_up,
  output logic o_adjust_down,
  output logic o_locked,
  output logic [TON_W-1:0] o_high_on_time
);
  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  // refused at elaboration: the reset and bound constants are sized for these widths
  if (TON_W != `ZDT_TON_W || TZ_W != `ZDT_TZ_W || LS_W != `ZDT_LSENSE_W) begin : g_width_check
    $error("zdt_tuner: widths must match the constant header");
  end

  localparam int LOCK_N = `ZDT_LOCK_CYCLES;

  // ----------------------------------------------------------------------
  // input synchronisers: pins are outside the clock domain
  // ----------------------------------------------------------------------
  logic [1:0] sws_sync;
  logic [1:0] zcd_sync;
  logic zcd_d;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sws_sync <= 2'h0;
      zcd_sync <= 2'h0;
      zcd_d <= 1'b0;
    end else begin
      sws_sync <= {sws_sync[0], i_zvs_threshold};
      zcd_sync <= {zcd_sync[0], i_zero_current_detect};
      zcd_d <= zcd_sync[1];
    end
  end
  wire logic sw_low = sws_sync[1];
  wire logic zero_current_detect = zcd_sync[1];
  wire logic zcd_rise = zero_current_detect & ~zcd_d;
  wire logic zcd_fall = ~zero_current_detect & zcd_d;

  // ----------------------------------------------------------------------
  // first dead-time: minimum plus linear extension below the knee
  // ----------------------------------------------------------------------
  // extension = min * 140% * (knee - i) / knee, clamped at 140% of min
  logic [TZ_W+LS_W+8:0] ext_full;
  logic [TZ_W+1:0] tz_len;
  always_comb begin
    ext_full = '0;
    if (i_line_sense_current < `ZDT_LSENSE_KNEE) begin
      ext_full = (TZ_W+LS_W+9)'(i_delay_program) * (TZ_W+LS_W+9)'(`ZDT_TZ_EXT_PCT)
               * (TZ_W+LS_W+9)'(`ZDT_LSENSE_KNEE - i_line_sense_current); // R7
    end
    tz_len = (TZ_W+2)'(i_delay_program)
           + (TZ_W+2)'(ext_full / ((TZ_W+LS_W+9)'(100) * (TZ_W+LS_W+9)'(`ZDT_LSENSE_KNEE)));
  end

  // ----------------------------------------------------------------------
  // switching sequence
  // ----------------------------------------------------------------------
  zdt_state_e state, next_state;
  logic [TON_W-1:0] cnt, next_cnt;
  logic [TON_W-1:0] ton, next_ton;
  logic [TZ_W+1:0] tz_cnt, next_tz_cnt;
  logic sw_seen, next_sw_seen;
  zdt_gates_s gates, next_gates;
  zdt_tune_s tune, next_tune;
  logic [4:0] cyc, next_cyc;
  logic last_dir, next_last_dir;

  // one process holds the cycle state; the gates never overlap by construction
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ton = ton;
    next_tz_cnt = tz_cnt;
    next_sw_seen = sw_seen;
    next_gates = gates;
    next_tune = tune;
    next_tune.adjust_up = 1'b0;
    next_tune.adjust_down = 1'b0;
    next_cyc = cyc;
    next_last_dir = last_dir;
    case (state)
      ZDT_IDLE: begin
        next_gates = '0;
        // from idle, the low side starts only on a fresh detect rising edge
        if (i_enable && zcd_rise) begin // R9
          next_state = ZDT_LOW_ON;
          next_gates.low_side_gate = 1'b1;
          next_cnt = '0;
        end
      end
      ZDT_LOW_ON: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= i_low_on_time) begin
          next_gates.low_side_gate = 1'b0; // R6
          next_state = ZDT_WAIT_FALL;
        end
      end
      ZDT_WAIT_FALL: begin
        // dead-time closes on the slope-driven detect fall, no fixed delay
        if (zcd_fall) begin // R10 R11
          next_gates.high_side_gate = 1'b1;
          next_state = ZDT_HIGH_ON;
          next_cnt = '0;
        end
      end
      ZDT_HIGH_ON: begin
        next_cnt = cnt + 1'b1;
        if (cnt >= ton) begin
          next_gates.high_side_gate = 1'b0; // R6
          next_state = ZDT_TZ_WAIT;
          next_tz_cnt = '0;
          next_sw_seen = 1'b0;
        end
      end
      ZDT_TZ_WAIT: begin
        next_tz_cnt = tz_cnt + 1'b1;
        if (sw_low) begin
          next_sw_seen = 1'b1; // R1
        end
        if (tz_cnt >= tz_len) begin
          // one step per cycle, direction from the discriminator
          if (sw_seen || sw_low) begin
            next_tune.adjust_down = 1'b1; // R3
            if (ton > `ZDT_TON_MIN) next_ton = ton - 1'b1; // R4
            next_last_dir = 1'b0;
          end else begin
            next_tune.adjust_up = 1'b1; // R2
            if (ton < `ZDT_TON_MAX) next_ton = ton + 1'b1; // R4
            next_last_dir = 1'b1;
          end
          if (cyc < 5'(LOCK_N)) next_cyc = cyc + 1'b1;
          // the first judgement has no earlier direction to reverse
          if (cyc != 5'h0 && last_dir == (sw_seen || sw_low)) next_tune.locked = 1'b1; // R5
          // resample detect: a recovered dip vetoes the low-side turn-on
          if (zero_current_detect && i_enable) begin // R8
            next_gates.low_side_gate = 1'b1;
            next_state = ZDT_LOW_ON;
            next_cnt = '0;
          end else begin
            next_state = ZDT_IDLE; // R9
          end
        end
      end
      default: begin
        next_state = ZDT_IDLE;
        next_gates = '0;
      end
    endcase
  end

  // short reset on-time makes the start hard switched until tuned
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ZDT_IDLE;
      cnt <= '0;
      ton <= `ZDT_TON_RESET; // R5
      tz_cnt <= '0;
      sw_seen <= 1'b0;
      gates <= '0;
      tune <= '0;
      cyc <= '0;
      last_dir <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ton <= next_ton;
      tz_cnt <= next_tz_cnt;
      sw_seen <= next_sw_seen;
      gates <= next_gates;
      tune <= next_tune;
      cyc <= next_cyc;
      last_dir <= next_last_dir;
    end
  end

  assign o_high_side_gate = gates.high_side_gate;
  assign o_low_side_gate = gates.low_side_gate;
  assign o_adjust_up = tune.adjust_up;
  assign o_adjust_down = tune.adjust_down;
  assign o_locked = tune.locked;
  assign o_high_on_time = ton;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_no_overlap;
    @(posedge i_clk) disable iff (i_rst) !(o_high_side_gate && o_low_side_gate);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("gates overlap"); // R6

  property p_step_one;
    @(posedge i_clk) disable iff (i_rst)
      (o_adjust_up || o_adjust_down) |->
        (o_high_on_time == $past(o_high_on_time) + 1'b1) ||
        (o_high_on_time == $past(o_high_on_time) - 1'b1) ||
        (o_high_on_time == $past(o_high_on_time));
  endproperty
  a_step_one: assert property (p_step_one) else $error("on-time moved more than one step"); // R4

  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
      !(o_adjust_up || o_adjust_down) |-> $stable(o_high_on_time);
  endproperty
  a_hold: assert property (p_hold) else $error("on-time moved without an adjust pulse"); // R4

  property p_up_dir;
    @(posedge i_clk) disable iff (i_rst)
      o_adjust_up && $past(o_high_on_time) < `ZDT_TON_MAX
        |-> o_high_on_time == $past(o_high_on_time) + 1'b1;
  endproperty
  a_up_dir: assert property (p_up_dir) else $error("up pulse did not lengthen"); // R2

  property p_down_dir;
    @(posedge i_clk) disable iff (i_rst)
      o_adjust_down && $past(o_high_on_time) > `ZDT_TON_MIN
        |-> o_high_on_time == $past(o_high_on_time) - 1'b1;
  endproperty
  a_down_dir: assert property (p_down_dir) else $error("down pulse did not shorten"); // R3

  property p_excl;
    @(posedge i_clk) disable iff (i_rst) !(o_adjust_up && o_adjust_down);
  endproperty
  a_excl: assert property (p_excl) else $error("both adjust pulses"); // R1

  property p_veto;
    @(posedge i_clk) disable iff (i_rst)
      (state == ZDT_TZ_WAIT && tz_cnt >= tz_len && !zero_current_detect) |=> !o_low_side_gate;
  endproperty
  a_veto: assert property (p_veto) else $error("low side on without valid detect"); // R9

  property p_hs_on_fall;
    @(posedge i_clk) disable iff (i_rst)
      (state == ZDT_WAIT_FALL && zcd_fall) |=> o_high_side_gate;
  endproperty
  a_hs_on_fall: assert property (p_hs_on_fall) else $error("high side late after fall"); // R11

  property p_tz_min;
    @(posedge i_clk) disable iff (i_rst)
      $fell(o_high_side_gate) |-> !o_low_side_gate [*2];
  endproperty
  a_tz_min: assert property (p_tz_min) else $error("first dead-time too short"); // R6
endmodule // zdt_tuner

// >>> testbench/zdt_flyback_model.sv
// stand-in for the flyback stage: switches, switch node and aux comparators
// assumes registered gate levels from the tuner on the same clock
module zdt_flyback_model #(
  parameter int TARGET = 14
) (
  input wire logic i_clk,
  input wire logic i_high_side_gate,
  input wire logic i_low_side_gate,
  input wire logic i_kick,
  input wire logic i_dip,
  input wire logic [3:0] i_lag,
  output logic o_zvs_threshold,
  output logic o_zero_current_detect
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] width;
  logic [3:0] lag_cnt, thr_cnt, dip_cnt;
  logic high_q, low_q;
  initial {width, lag_cnt, thr_cnt, dip_cnt, high_q, low_q, o_zero_current_detect} = '0;
  // node sits low while the low side conducts; a valley needs enough on-time
  assign o_zvs_threshold = i_low_side_gate | (thr_cnt != 4'h0);
  // --------------------------------
  // switch node and winding
  // --------------------------------
  always @(posedge i_clk) begin
    high_q <= i_high_side_gate;
    low_q <= i_low_side_gate;
    width <= i_high_side_gate ? width + 10'h001 : 10'h000;
    if (thr_cnt != 4'h0) thr_cnt <= thr_cnt - 4'h1;
    if (dip_cnt != 4'h0) dip_cnt <= dip_cnt - 4'h1;
    if (lag_cnt != 4'h0) lag_cnt <= lag_cnt - 4'h1;
    if (high_q && !i_high_side_gate) begin
      if (width >= TARGET) thr_cnt <= 4'h4;
      o_zero_current_detect <= 1'b1;
      dip_cnt <= i_dip ? 4'h2 : 4'h0;
    end
    // a recovered dip drops detect again well before the delay expires
    if (dip_cnt == 4'h1) o_zero_current_detect <= 1'b0;
    // demagnetising ends a few cycles after the low side opens (slow or prompt)
    if (low_q && !i_low_side_gate) lag_cnt <= i_lag;
    if (lag_cnt == 4'h1) o_zero_current_detect <= 1'b0;
    if (i_kick) o_zero_current_detect <= 1'b1;
  end
endmodule // zdt_flyback_model

// >>> testbench/test_zvs_deadtime_tuner.sv
// self-checking bench for the on-time tuner and the dead-time timing
// assumes the flyback stand-in model and a 100 MHz clock
`include "zdt_map.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((ex) !== (gt)) begin failures++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module test_zvs_deadtime_tuner;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int w; logic up; int dead;} zdt_note_s;
  zdt_note_s notes[$];
  zdt_note_s nt;
  logic clk = 1'b0, rst = 1'b1, en = 1'b0, kick = 1'b0, dip = 1'b0;
  logic thr, zero_current_detect, hi, lo, up, dn, locked;
  logic [7:0] tz_min = 8'h0a, line = `ZDT_LSENSE_KNEE;
  logic [9:0] low_on = `ZDT_LOW_ON_RESET, ton_q;
  logic [3:0] lag = 4'h3;
  int failures = 0, n_tests = 0, seed = 32'h4ed4af25, ton = `ZDT_TON_RESET;
  int w_run = 0, w_seen = 0, d_cnt = 0, d_exp = 0, l_cnt = 0;
  always #5 clk = ~clk;
  zdt_tuner DUT (.i_clk(clk), .i_rst(rst), .i_enable(en), .i_zvs_threshold(thr),
    .i_zero_current_detect(zero_current_detect), .i_delay_program(tz_min), .i_line_sense_current(line),
    .i_low_on_time(low_on), .o_high_side_gate(hi), .o_low_side_gate(lo), .o_adjust_up(up),
    .o_adjust_down(dn), .o_locked(locked), .o_high_on_time(ton_q));
  zdt_flyback_model #(.TARGET(14)) plant (.i_clk(clk), .i_high_side_gate(hi),
    .i_low_side_gate(lo), .i_kick(kick), .i_dip(dip), .i_lag(lag),
    .o_zvs_threshold(thr), .o_zero_current_detect(zero_current_detect));
  // --------------------------------
  // watcher: pulse widths and dead-times against the oldest note
  // --------------------------------
  always @(posedge clk) begin
    #2;
    if (hi && lo) `CHK("gate overlap", 1'b0, 1'b1)
    if (hi) w_run++;
    else if (w_run != 0) begin
      w_seen = w_run;
      w_run = 0;
      d_cnt = 0;
    end
    if (!hi && !lo) d_cnt++;
    if (up || dn) begin
      if (notes.size() == 0) `CHK("adjust pulse", 2'b00, {up, dn})
      else begin
        nt = notes.pop_front();
        `CHK("high on-time", nt.w, w_seen)
        `CHK("adjust dir", {nt.up, !nt.up}, {up, dn})
        d_exp = nt.dead;
      end
    end
    // a dip cycle has no dead-time to measure, so its note carries zero
    if (lo && d_cnt != 0) begin
      if (d_exp != 0) `CHK("dead-time", d_exp, d_cnt)
      d_cnt = 0;
    end
    // second dead-time: model lag plus two sync stages, edge detect and gate register
    if (lo) l_cnt = 1;
    else if (l_cnt != 0 && !hi) l_cnt++;
    else if (l_cnt != 0 && hi) begin
      `CHK("second dead-time", lag + 4, l_cnt - 1)
      l_cnt = 0;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait until only `left` notes remain
  task automatic wait_q(input int left);
    for (int c = 0; notes.size() > left; c++) begin
      if (c == 20000) begin
        failures++;
        $display("Error notes left expected %0d seen %0d", left, notes.size());
        wrap_up();
      end
      tick(1);
    end
  endtask
  // notes n cycles ahead; the last cycle ends in a recovered dip
  task automatic run(input string nm, input int n, input int lv);
    zdt_note_s x;
    int tz;
    line = lv[7:0];
    lag = 4'h1 + 4'($random(seed) & 7);
    tz = tz_min + ((lv < `ZDT_LSENSE_KNEE) ? tz_min * `ZDT_TZ_EXT_PCT
      * (`ZDT_LSENSE_KNEE - lv) / (100 * `ZDT_LSENSE_KNEE) : 0);
    for (int k = 0; k < n; k++) begin
      x.w = ton + 1;
      x.up = (x.w < 14);
      x.dead = (k == n - 1) ? 0 : tz + 1;
      ton = x.up ? ton + 1 : ton - 1;
      notes.push_back(x);
    end
    kick = 1'b1;
    tick(1);
    kick = 1'b0;
    wait_q(1);
    dip = 1'b1;
    wait_q(0);
    dip = 1'b0;
    tick(60);
    `CHK("low gate after dip", 1'b0, lo)
    $display("%s done", nm);
  endtask
  initial begin
    tick(20);
    rst = 1'b0;
    en = 1'b1;
    tick(3);
    run("tuning lock", 16, `ZDT_LSENSE_KNEE);
    `CHK("locked", 1'b1, locked)
    `CHK("on-time", ton[9:0], ton_q)
    for (int r = 0; r < 3; r++) run("line feed", 4, (r == 0) ? 0 : $random(seed) & 255);
    wrap_up();
  end
endmodule // test_zvs_deadtime_tuner
